//--- include/bgd_consts.vh
// constants for the bar graph display controller
// assumes inclusion by bare name from each design file
`ifndef BGD_CONSTS_VH
`define BGD_CONSTS_VH

// clock and press timing
`define BGD_CLK_HZ 25000000
`define BGD_MS_PER_S 1000
`define BGD_SHORT_MIN_MS 100
`define BGD_LONG_MS 3000
`define BGD_MODEID_TMO_MS 3000
`define BGD_ST_HOLD_MS 1000
`define BGD_ST_TMO_MS 10000
`define BGD_TMR_W 28

// segment layout and blink rates
`define BGD_SEG_N 5
`define BGD_SEG_OFF 5'h00
`define BGD_SEG_ALL 5'h1f
`define BGD_SEG_FIRST 5'h01
`define BGD_BLINK_W 23
`define BGD_BLINK_FAST 21
`define BGD_BLINK_FASTER 19

// modes
`define BGD_MODE_W 3
`define BGD_MODE_EFF 3'h1
`define BGD_MODE_RATE 3'h2
`define BGD_MODE_TEST 3'h3
`define BGD_MODE_LAST 3'h5

// percent values
`define BGD_PCT_W 7
`define BGD_PCT_ZERO 7'h00
`define BGD_PCT_FULL 7'h64
`define BGD_WINDOW_SCANS 7'h64
`define BGD_SCAN_ONE 7'h01

// thresholds, efficiency and self-test
`define BGD_TE1 7'h01
`define BGD_TE2 7'h19
`define BGD_TE3 7'h32
`define BGD_TE4 7'h4b
`define BGD_TE5 7'h60
// thresholds, read rate
`define BGD_TR1 7'h60
`define BGD_TR2 7'h61
`define BGD_TR3 7'h62
`define BGD_TR4 7'h63
`define BGD_TR5 7'h64

// read rate counters
`define BGD_CNT_W 16
`define BGD_CNT_ONE 16'h0001
`define BGD_CNT_ZERO 16'h0000
`define BGD_DIVD_W 23
`define BGD_DIV_IDX_W 5

// forced serial settings during self-test
`define BGD_BAUD_W 14
`define BGD_BAUD 14'h2580
`define BGD_DATA_BITS 4'h7
`define BGD_STOP_BITS 2'h2

// menu dumps
`define BGD_MENU_W 13
`define BGD_MENU_A 13'h1388
`define BGD_MENU_B 13'h1389
`define BGD_MENU_C 13'h138b
`define BGD_DUMP_IDX_W 2
`define BGD_DUMP_LAST 2'h2

`endif

//--- logic/bgd_sync.v
// three-stage synchroniser with agreement filter for a pin input
// assumes a single asynchronous input and one clock domain
`timescale 1ns/1ps
`include "bgd_consts.vh"
module bgd_sync (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // pin side
    input wire pin_in,
    // synchronous side
    output reg level_reg
);
    reg ff1_reg;
    reg ff2_reg;
    reg ff3_reg;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ff1_reg <= 1'b0;
            ff2_reg <= 1'b0;
            ff3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            ff1_reg <= pin_in;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            // change counts once stages two and three agree
            if (ff2_reg == ff3_reg) begin
                level_reg <= ff3_reg;
            end
        end
    end
endmodule

//--- logic/bgd_divider.v
// iterative restoring divider, one quotient bit per clock
// assumes start only while not busy; divisor nonzero
`timescale 1ns/1ps
`include "bgd_consts.vh"
module bgd_divider #(
    parameter NW = 23,
    parameter DW = 16,
    parameter IW = 5
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // request
    input wire start,
    input wire [NW-1:0] dividend,
    input wire [DW-1:0] divisor,
    // answer
    output reg busy_reg,
    output reg done_reg,
    output reg [NW-1:0] quot_reg
);
    localparam [IW-1:0] LAST_IDX = NW[IW-1:0] - 1'b1;
    reg [DW:0] rem_reg;
    reg [DW-1:0] dsr_reg;
    reg [IW-1:0] idx_reg;
    wire [DW:0] shifted;
    wire [DW:0] diff;

    assign shifted = {rem_reg[DW-1:0], quot_reg[NW-1]};
    assign diff = shifted - {1'b0, dsr_reg};

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            quot_reg <= {NW{1'b0}};
            rem_reg <= {(DW+1){1'b0}};
            dsr_reg <= {DW{1'b0}};
            idx_reg <= {IW{1'b0}};
        end else begin
            done_reg <= 1'b0;
            if (start && !busy_reg) begin
                busy_reg <= 1'b1;
                quot_reg <= dividend;
                dsr_reg <= divisor;
                rem_reg <= {(DW+1){1'b0}};
                idx_reg <= {IW{1'b0}};
            end else if (busy_reg) begin
                // quotient bits shift in where dividend bits leave
                if (!diff[DW]) begin
                    rem_reg <= diff;
                    quot_reg <= {quot_reg[NW-2:0], 1'b1};
                end else begin
                    rem_reg <= shifted;
                    quot_reg <= {quot_reg[NW-2:0], 1'b0};
                end
                if (idx_reg == LAST_IDX) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
                idx_reg <= idx_reg + 1'b1;
            end
        end
    end
endmodule

//--- logic/bgd_display_ctrl.v
// five-segment bar graph mode and display controller
// assumes decode, trigger and serial logic on the same clock
// Notes on behaviour
// - five segments, lowest value at left
// - efficiency: good matching scans per 100
// - efficiency, self-test thresholds 1/25/50/75/96
// - efficiency refreshed once per 100 scans
// - read rate: good reads over triggers
// - both read rate counters 16 bits
// - read rate thresholds 96 to 100
// - read rate refreshed each trigger end
// - short press 100ms-3s, acts on release
// - over 3s long press in mode id resets mode data
// - power-on enters data display state
// - first short press shows mode number
// - short presses advance mode, wrap
// - long press never advances mode
// - 3s idle returns to data display
// - self-test blinks fast, 1s hold faster
// - diag read dumps menus; 10s timeout
// - self-test forces 9600 7E2 serial
// - clear graph, dump three menus both ports
`timescale 1ns/1ps
`include "bgd_consts.vh"
module bgd_display_ctrl #(
    parameter CLK_HZ = `BGD_CLK_HZ,
    parameter SHORT_MIN_CYC = CLK_HZ / `BGD_MS_PER_S * `BGD_SHORT_MIN_MS,
    parameter LONG_CYC = CLK_HZ / `BGD_MS_PER_S * `BGD_LONG_MS,
    parameter MODEID_TMO_CYC = CLK_HZ / `BGD_MS_PER_S * `BGD_MODEID_TMO_MS,
    parameter ST_HOLD_CYC = CLK_HZ / `BGD_MS_PER_S * `BGD_ST_HOLD_MS,
    parameter ST_TMO_CYC = CLK_HZ / `BGD_MS_PER_S * `BGD_ST_TMO_MS
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // pushbutton pin, high while closed
    input wire button_in,
    // scan results from decode logic
    input wire scan_done,
    input wire scan_decoded,
    input wire scan_match,
    // trigger cycle results
    input wire trigger_end,
    input wire good_read,
    // self-test events
    input wire diag_read,
    input wire dump_ack,
    // bar graph and mode
    output reg [`BGD_SEG_N-1:0] seg_reg,
    output reg [`BGD_MODE_W-1:0] mode_reg,
    // self-test laser and forced serial settings
    output reg laser_on_reg,
    output reg ser_force_reg,
    output reg [`BGD_BAUD_W-1:0] ser_baud_reg,
    output reg [3:0] ser_data_bits_reg,
    output reg ser_parity_even_reg,
    output reg [1:0] ser_stop_bits_reg,
    // menu dump requests
    output reg dump_req_reg,
    output reg [`BGD_MENU_W-1:0] dump_menu_reg,
    output reg dump_rs485_reg,
    output reg dump_rs232_reg
);
    localparam [2:0] S_DATA = 3'h0;
    localparam [2:0] S_MODEID = 3'h1;
    localparam [2:0] S_ST_ARM = 3'h2;
    localparam [2:0] S_ST_RUN = 3'h3;
    localparam [2:0] S_ST_DUMP = 3'h4;
    localparam [`BGD_TMR_W-1:0] T_SHORT = SHORT_MIN_CYC[`BGD_TMR_W-1:0];
    localparam [`BGD_TMR_W-1:0] T_LONG = LONG_CYC[`BGD_TMR_W-1:0];
    localparam [`BGD_TMR_W-1:0] T_MID = MODEID_TMO_CYC[`BGD_TMR_W-1:0];
    localparam [`BGD_TMR_W-1:0] T_HOLD = ST_HOLD_CYC[`BGD_TMR_W-1:0];
    localparam [`BGD_TMR_W-1:0] T_STMO = ST_TMO_CYC[`BGD_TMR_W-1:0];

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`BGD_TMR_W-1:0] hold_reg;
    reg [`BGD_TMR_W-1:0] tmr_reg;
    reg btn_prev_reg;
    reg [`BGD_BLINK_W-1:0] blink_reg;
    reg [`BGD_PCT_W-1:0] scan_cnt_reg;
    reg [`BGD_PCT_W-1:0] good_scan_reg;
    reg [`BGD_PCT_W-1:0] eff_reg;
    reg [`BGD_CNT_W-1:0] trig_cnt_reg;
    reg [`BGD_CNT_W-1:0] good_cnt_reg;
    reg [`BGD_PCT_W-1:0] rate_reg;
    reg [`BGD_PCT_W-1:0] st_val_reg;
    reg div_start_reg;
    reg arm_done_reg;
    reg [`BGD_DUMP_IDX_W-1:0] dump_idx_reg;
    reg [`BGD_SEG_N-1:0] seg_next;
    wire btn;
    wire short_press_release;
    wire long_press_hold;
    wire [`BGD_DIVD_W-1:0] good_x100;
    wire div_busy;
    wire div_done;
    wire [`BGD_DIVD_W-1:0] div_quot;
    wire [`BGD_PCT_W-1:0] rate_pct;

    // button pin crossing
    bgd_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(button_in),
        .level_reg(btn)
    );

    // good reads times 100 by shifts
    assign good_x100 = {1'b0, good_cnt_reg, 6'h00}
        + {2'b00, good_cnt_reg, 5'h00}
        + {5'h00, good_cnt_reg, 2'h0};

    bgd_divider #(
        .NW(`BGD_DIVD_W),
        .DW(`BGD_CNT_W),
        .IW(`BGD_DIV_IDX_W)
    ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .start(div_start_reg),
        .dividend(good_x100),
        .divisor(trig_cnt_reg),
        .busy_reg(div_busy),
        .done_reg(div_done),
        .quot_reg(div_quot)
    );

    // quotient saturates at full scale, truncation kept
    assign rate_pct = (div_quot > {16'h0000, `BGD_PCT_FULL}) ?
        `BGD_PCT_FULL : div_quot[`BGD_PCT_W-1:0];

    // press classification on release
    assign short_press_release = btn_prev_reg && !btn
        && hold_reg >= T_SHORT && hold_reg < T_LONG;
    // long press fires once while still held
    assign long_press_hold = btn && hold_reg == T_LONG;

    // bar fill from value; segment 1 is bit 0
    function [`BGD_SEG_N-1:0] bars;
        input [`BGD_PCT_W-1:0] v;
        input [`BGD_PCT_W-1:0] t1;
        input [`BGD_PCT_W-1:0] t2;
        input [`BGD_PCT_W-1:0] t3;
        input [`BGD_PCT_W-1:0] t4;
        input [`BGD_PCT_W-1:0] t5;
        begin
            bars = {v >= t5, v >= t4, v >= t3, v >= t2, v >= t1};
        end
    endfunction

    // next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_DATA: begin
                if (short_press_release) begin
                    state_next = S_MODEID;
                end else if (mode_reg == `BGD_MODE_TEST && !arm_done_reg) begin
                    state_next = S_ST_ARM;
                end
            end
            S_MODEID: begin
                if (!btn && tmr_reg >= T_MID) begin
                    state_next = S_DATA;
                end
            end
            S_ST_ARM: begin
                if (btn && hold_reg >= T_HOLD) begin
                    state_next = S_ST_RUN;
                end else if (tmr_reg >= T_STMO) begin
                    state_next = S_DATA;
                end
            end
            S_ST_RUN: begin
                if (diag_read) begin
                    state_next = S_ST_DUMP;
                end else if (tmr_reg >= T_STMO) begin
                    state_next = S_DATA;
                end
            end
            S_ST_DUMP: begin
                if (dump_ack && dump_idx_reg == `BGD_DUMP_LAST) begin
                    state_next = S_DATA;
                end
            end
            default: begin
                state_next = S_DATA;
            end
        endcase
    end

    // segment pattern per state
    always @* begin
        seg_next = `BGD_SEG_OFF;
        case (state_reg)
            S_DATA: begin
                // live measurement of current mode
                case (mode_reg)
                    `BGD_MODE_EFF: seg_next = bars(eff_reg, `BGD_TE1,
                        `BGD_TE2, `BGD_TE3, `BGD_TE4, `BGD_TE5);
                    `BGD_MODE_RATE: seg_next = bars(rate_reg, `BGD_TR1,
                        `BGD_TR2, `BGD_TR3, `BGD_TR4, `BGD_TR5);
                    `BGD_MODE_TEST: seg_next = bars(st_val_reg, `BGD_TE1,
                        `BGD_TE2, `BGD_TE3, `BGD_TE4, `BGD_TE5);
                    default: seg_next = `BGD_SEG_OFF;
                endcase
            end
            S_MODEID: begin
                // one steady segment names the mode
                seg_next = `BGD_SEG_FIRST << (mode_reg - `BGD_MODE_EFF);
            end
            S_ST_ARM: begin
                seg_next = blink_reg[`BGD_BLINK_FAST] ?
                    `BGD_SEG_ALL : `BGD_SEG_OFF;
            end
            S_ST_RUN: begin
                seg_next = blink_reg[`BGD_BLINK_FASTER] ?
                    `BGD_SEG_ALL : `BGD_SEG_OFF;
            end
            S_ST_DUMP: begin
                seg_next = `BGD_SEG_OFF;
            end
            default: begin
                seg_next = `BGD_SEG_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_DATA;
            hold_reg <= {`BGD_TMR_W{1'b0}};
            tmr_reg <= {`BGD_TMR_W{1'b0}};
            btn_prev_reg <= 1'b0;
            blink_reg <= {`BGD_BLINK_W{1'b0}};
            scan_cnt_reg <= `BGD_PCT_ZERO;
            good_scan_reg <= `BGD_PCT_ZERO;
            eff_reg <= `BGD_PCT_ZERO;
            trig_cnt_reg <= `BGD_CNT_ZERO;
            good_cnt_reg <= `BGD_CNT_ZERO;
            rate_reg <= `BGD_PCT_FULL;
            st_val_reg <= `BGD_PCT_ZERO;
            div_start_reg <= 1'b0;
            arm_done_reg <= 1'b0;
            dump_idx_reg <= {`BGD_DUMP_IDX_W{1'b0}};
            seg_reg <= `BGD_SEG_OFF;
            mode_reg <= `BGD_MODE_EFF;
            laser_on_reg <= 1'b0;
            ser_force_reg <= 1'b0;
            ser_baud_reg <= `BGD_BAUD;
            ser_data_bits_reg <= `BGD_DATA_BITS;
            ser_parity_even_reg <= 1'b1;
            ser_stop_bits_reg <= `BGD_STOP_BITS;
            dump_req_reg <= 1'b0;
            dump_menu_reg <= `BGD_MENU_A;
            dump_rs485_reg <= 1'b0;
            dump_rs232_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            seg_reg <= seg_next;
            btn_prev_reg <= btn;
            blink_reg <= blink_reg + 1'b1;
            div_start_reg <= 1'b0;
            // closure length, saturating above the long limit
            if (!btn) begin
                hold_reg <= {`BGD_TMR_W{1'b0}};
            end else if (hold_reg <= T_LONG) begin
                hold_reg <= hold_reg + 1'b1;
            end
            // state timer; any button activity restarts it in mode id
            if (state_next != state_reg || (state_reg == S_MODEID && btn)) begin
                tmr_reg <= {`BGD_TMR_W{1'b0}};
            end else if (tmr_reg < T_STMO) begin
                tmr_reg <= tmr_reg + 1'b1;
            end
            if (mode_reg != `BGD_MODE_TEST) begin
                arm_done_reg <= 1'b0;
            end else if (state_reg == S_ST_ARM && state_next != S_ST_ARM) begin
                arm_done_reg <= 1'b1;
            end
            // mode advance and wrap
            if (state_reg == S_MODEID && short_press_release) begin
                if (mode_reg == `BGD_MODE_LAST) begin
                    mode_reg <= `BGD_MODE_EFF;
                end else begin
                    mode_reg <= mode_reg + 1'b1;
                end
            end
            // efficiency window of 100 scans
            if (scan_done) begin
                if (scan_cnt_reg == `BGD_WINDOW_SCANS - `BGD_SCAN_ONE) begin
                    scan_cnt_reg <= `BGD_PCT_ZERO;
                    good_scan_reg <= `BGD_PCT_ZERO;
                    eff_reg <= good_scan_reg
                        + {6'h00, scan_decoded && scan_match};
                end else begin
                    scan_cnt_reg <= scan_cnt_reg + 1'b1;
                    good_scan_reg <= good_scan_reg
                        + {6'h00, scan_decoded && scan_match};
                end
            end
            // trigger totals and refresh
            if (trigger_end) begin
                trig_cnt_reg <= trig_cnt_reg + `BGD_CNT_ONE;
                if (good_read) begin
                    good_cnt_reg <= good_cnt_reg + `BGD_CNT_ONE;
                end
                div_start_reg <= 1'b1;
            end
            if (div_done) begin
                rate_reg <= (trig_cnt_reg == `BGD_CNT_ZERO) ?
                    `BGD_PCT_FULL : rate_pct;
            end
            // long press resets current mode data
            if (state_reg == S_MODEID && long_press_hold) begin
                case (mode_reg)
                    `BGD_MODE_EFF: begin
                        eff_reg <= `BGD_PCT_ZERO;
                        scan_cnt_reg <= `BGD_PCT_ZERO;
                        good_scan_reg <= `BGD_PCT_ZERO;
                    end
                    `BGD_MODE_RATE: begin
                        trig_cnt_reg <= `BGD_CNT_ZERO;
                        good_cnt_reg <= `BGD_CNT_ZERO;
                        rate_reg <= `BGD_PCT_FULL;
                    end
                    `BGD_MODE_TEST: st_val_reg <= `BGD_PCT_ZERO;
                    default: st_val_reg <= st_val_reg;
                endcase
            end
            // laser and forced serial format while testing
            laser_on_reg <= state_next == S_ST_RUN;
            ser_force_reg <= state_next == S_ST_RUN
                || state_next == S_ST_DUMP;
            // menu dumps in sequence on both ports
            if (state_reg == S_ST_RUN && diag_read) begin
                dump_idx_reg <= {`BGD_DUMP_IDX_W{1'b0}};
                dump_menu_reg <= `BGD_MENU_A;
                dump_req_reg <= 1'b1;
                dump_rs485_reg <= 1'b1;
                dump_rs232_reg <= 1'b1;
                st_val_reg <= `BGD_PCT_FULL;
            end else if (state_reg == S_ST_DUMP && dump_ack) begin
                dump_idx_reg <= dump_idx_reg + 1'b1;
                if (dump_idx_reg == `BGD_DUMP_LAST) begin
                    dump_req_reg <= 1'b0;
                    dump_rs485_reg <= 1'b0;
                    dump_rs232_reg <= 1'b0;
                end else if (dump_idx_reg == {`BGD_DUMP_IDX_W{1'b0}}) begin
                    dump_menu_reg <= `BGD_MENU_B;
                end else begin
                    dump_menu_reg <= `BGD_MENU_C;
                end
            end
        end
    end
endmodule

//--- tb/bgd_display_props.sv
// port checks for the bar graph controller
// assumes binding into bgd_display_ctrl, one clock domain
`timescale 1ns/1ps
`include "bgd_consts.vh"
module bgd_display_props (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // inputs watched
    input wire button_in,
    input wire dump_ack,
    // outputs watched
    input wire [`BGD_SEG_N-1:0] seg_reg,
    input wire [`BGD_MODE_W-1:0] mode_reg,
    input wire laser_on_reg,
    input wire ser_force_reg,
    input wire [`BGD_BAUD_W-1:0] ser_baud_reg,
    input wire [3:0] ser_data_bits_reg,
    input wire ser_parity_even_reg,
    input wire [1:0] ser_stop_bits_reg,
    input wire dump_req_reg,
    input wire [`BGD_MENU_W-1:0] dump_menu_reg,
    input wire dump_rs485_reg,
    input wire dump_rs232_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_mode_range: assert property (mode_reg >= 3'h1 && mode_reg <= 3'h5)
        else $error("mode out of range");
    a_mode_step: assert property ($changed(mode_reg) |->
        mode_reg == $past(mode_reg) + 3'h1 ||
        (mode_reg == 3'h1 && $past(mode_reg) == 3'h5))
        else $error("mode did not step by one");
    a_mode_release: assert property ($changed(mode_reg) |->
        !$past(button_in, 3))
        else $error("mode changed with button held");
    a_dump_ports: assert property (dump_rs485_reg == dump_req_reg &&
        dump_rs232_reg == dump_req_reg)
        else $error("dump not on both ports");
    a_dump_clear: assert property (dump_req_reg && $past(dump_req_reg) |->
        seg_reg == 5'h00)
        else $error("graph not cleared in dump");
    a_ser_fixed: assert property (ser_force_reg |->
        ser_baud_reg == 14'h2580 && ser_data_bits_reg == 4'h7 &&
        ser_parity_even_reg && ser_stop_bits_reg == 2'h2)
        else $error("serial settings wrong");
    a_laser_force: assert property (laser_on_reg |-> ser_force_reg)
        else $error("laser on without forced serial");
    a_dump_start: assert property ($rose(dump_req_reg) |->
        dump_menu_reg == 13'h1388 && $past(laser_on_reg))
        else $error("dump start wrong");
    a_menu_next: assert property (dump_ack && dump_req_reg &&
        dump_menu_reg == 13'h1388 |=> dump_menu_reg == 13'h1389)
        else $error("second menu wrong");
    a_menu_last: assert property (dump_ack && dump_req_reg &&
        dump_menu_reg == 13'h1389 |=> dump_menu_reg == 13'h138b)
        else $error("third menu wrong");
    a_dump_end: assert property (dump_ack && dump_req_reg &&
        dump_menu_reg == 13'h138b |=> !dump_req_reg && !ser_force_reg)
        else $error("dump did not end");

    c_dump: cover property ($rose(dump_req_reg));
    c_laser: cover property ($rose(laser_on_reg));
    c_wrap: cover property ($changed(mode_reg) && mode_reg == 3'h1);
endmodule

bind bgd_display_ctrl bgd_display_props u_props (
    .clk(clk), .arst_n(arst_n), .button_in(button_in), .dump_ack(dump_ack),
    .seg_reg(seg_reg), .mode_reg(mode_reg), .laser_on_reg(laser_on_reg),
    .ser_force_reg(ser_force_reg), .ser_baud_reg(ser_baud_reg),
    .ser_data_bits_reg(ser_data_bits_reg),
    .ser_parity_even_reg(ser_parity_even_reg),
    .ser_stop_bits_reg(ser_stop_bits_reg), .dump_req_reg(dump_req_reg),
    .dump_menu_reg(dump_menu_reg), .dump_rs485_reg(dump_rs485_reg),
    .dump_rs232_reg(dump_rs232_reg)
);

//--- tb/bgd_operator_model.sv
// operator button, decode, trigger and serial ack model
// assumes the bench calls its tasks; outputs change at rising edges
`timescale 1ns/1ps
module bgd_operator_model (
    // clock
    input wire clk,
    // pushbutton
    output logic button_in,
    // decode and trigger results
    output logic scan_done,
    output logic scan_decoded,
    output logic scan_match,
    output logic trigger_end,
    output logic good_read,
    // self-test events
    output logic diag_read,
    output logic dump_ack
);
    initial begin
        {button_in, scan_done, scan_decoded, scan_match} = 4'h0;
        {trigger_end, good_read, diag_read, dump_ack} = 4'h0;
    end
    task automatic set_btn(input logic v);
        @(posedge clk);
        button_in <= v;
    endtask
    // closure held n cycles after the press edge
    task automatic press(input int n);
        set_btn(1'b1);
        repeat (n) @(posedge clk);
        button_in <= 1'b0;
    endtask
    // qualifiers flip outside the pulse
    task automatic scan(input logic dec, input logic mat);
        @(posedge clk);
        scan_done <= 1'b1;
        scan_decoded <= dec;
        scan_match <= mat;
        @(posedge clk);
        scan_done <= 1'b0;
        scan_decoded <= !dec;
        scan_match <= !mat;
    endtask
    task automatic trig(input logic good);
        @(posedge clk);
        trigger_end <= 1'b1;
        good_read <= good;
        @(posedge clk);
        trigger_end <= 1'b0;
        good_read <= !good;
        repeat (32) @(posedge clk);
    endtask
    // a low: diagnostic read, a high: dump finished
    task automatic ev(input logic a);
        @(posedge clk);
        diag_read <= !a;
        dump_ack <= a;
        @(posedge clk);
        diag_read <= 1'b0;
        dump_ack <= 1'b0;
    endtask
endmodule

//--- tb/bar_graph_mode_display_controller_tb_top.sv
// bench for the bar graph controller with shortened timings
// assumes the operator model drives every design input but clock and reset
`timescale 1ns/1ps
`include "bgd_consts.vh"
module bar_graph_mode_display_controller_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    wire button_in, scan_done, scan_decoded, scan_match;
    wire trigger_end, good_read, diag_read, dump_ack;
    wire [`BGD_SEG_N-1:0] seg_reg;
    wire [`BGD_MODE_W-1:0] mode_reg;
    wire laser_on_reg, ser_force_reg, ser_parity_even_reg;
    wire [`BGD_BAUD_W-1:0] ser_baud_reg;
    wire [3:0] ser_data_bits_reg;
    wire [1:0] ser_stop_bits_reg;
    wire dump_req_reg, dump_rs485_reg, dump_rs232_reg;
    wire [`BGD_MENU_W-1:0] dump_menu_reg;
    wire [20:0] ser_cfg = {ser_baud_reg, ser_data_bits_reg,
        ser_parity_even_reg, ser_stop_bits_reg};
    int n_fail = 0;
    int tests_run = 0;
    int win[8] = '{1, 25, 24, 50, 75, 95, 96, 0};
    logic [4:0] rate_exp[4] = '{5'h1f, 5'h07, 5'h01, 5'h00};
    logic [12:0] nxt[2] = '{13'h1389, 13'h138b};

    always #20 clk = ~clk;

    bgd_operator_model op (
        .clk(clk), .button_in(button_in), .scan_done(scan_done),
        .scan_decoded(scan_decoded), .scan_match(scan_match),
        .trigger_end(trigger_end), .good_read(good_read),
        .diag_read(diag_read), .dump_ack(dump_ack)
    );
    bgd_display_ctrl #(
        .SHORT_MIN_CYC(10), .LONG_CYC(100), .MODEID_TMO_CYC(100),
        .ST_HOLD_CYC(40), .ST_TMO_CYC(300)
    ) dut (
        .clk(clk), .arst_n(arst_n), .button_in(button_in),
        .scan_done(scan_done), .scan_decoded(scan_decoded),
        .scan_match(scan_match), .trigger_end(trigger_end),
        .good_read(good_read), .diag_read(diag_read), .dump_ack(dump_ack),
        .seg_reg(seg_reg), .mode_reg(mode_reg), .laser_on_reg(laser_on_reg),
        .ser_force_reg(ser_force_reg), .ser_baud_reg(ser_baud_reg),
        .ser_data_bits_reg(ser_data_bits_reg),
        .ser_parity_even_reg(ser_parity_even_reg),
        .ser_stop_bits_reg(ser_stop_bits_reg), .dump_req_reg(dump_req_reg),
        .dump_menu_reg(dump_menu_reg), .dump_rs485_reg(dump_rs485_reg),
        .dump_rs232_reg(dump_rs232_reg)
    );

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // settle just after an edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    // windows of 100 scans, three decoded scans off the majority
    task automatic t_eff;
        int k;
        logic [4:0] prev;
        prev = 5'h00;
        foreach (win[w]) begin
            k = win[w];
            for (int i = 0; i < 100; i++) begin
                op.scan(i < k + 3, i < k);
                if (i == 98) begin
                    wt(3);
                    chk(seg_reg, prev);
                end
            end
            prev = {k >= 96, k >= 75, k >= 50, k >= 25, k >= 1};
            wt(3);
            chk(seg_reg, prev);
        end
    endtask
    task automatic t_mode;
        logic [2:0] m;
        op.press(5);
        wt(12);
        chk({mode_reg, seg_reg}, {3'h1, 5'h00});
        m = 3'h1;
        for (int i = 0; i < 7; i++) begin
            op.press(20);
            wt(8);
            if (i > 0) m = (m == 3'h5) ? 3'h1 : m + 3'h1;
            chk({mode_reg, seg_reg}, {m, 5'h01 << (m - 3'h1)});
        end
        wt(110);
        chk(seg_reg, 5'h1f);
    endtask
    task automatic t_rate;
        for (int i = 0; i < 67; i++) begin
            op.trig(i < 64);
            if (i >= 63) begin
                wt(0);
                chk(seg_reg, rate_exp[i - 63]);
            end
        end
    endtask
    task automatic t_long;
        op.press(20);
        wt(8);
        chk({mode_reg, seg_reg}, {3'h2, 5'h02});
        op.press(130);
        wt(8);
        chk({mode_reg, seg_reg}, {3'h2, 5'h02});
        wt(110);
        chk(seg_reg, 5'h1f);
    endtask
    task automatic t_self;
        int n;
        op.press(20);
        wt(8);
        op.press(20);
        wt(8);
        chk({mode_reg, seg_reg}, {3'h3, 5'h04});
        wt(110);
        op.set_btn(1'b1);
        n = 0;
        while (laser_on_reg !== 1'b1 && n < 80) begin
            wt(1);
            n++;
        end
        if (n >= 80) begin
            n_fail++;
            stop_test();
        end
        chk({n >= 38, laser_on_reg, ser_force_reg}, 3'h7);
        chk(ser_cfg, {14'h2580, 4'h7, 1'b1, 2'h2});
        op.ev(1'b0);
        wt(1);
        chk({dump_req_reg, dump_rs485_reg, dump_rs232_reg, seg_reg}, 8'he0);
        chk(dump_menu_reg, 13'h1388);
        for (int i = 0; i < 3; i++) begin
            op.ev(1'b1);
            wt(0);
            chk(dump_req_reg, i < 2);
            if (i < 2) chk(dump_menu_reg, nxt[i]);
        end
        wt(60);
        op.set_btn(1'b0);
        wt(10);
        chk({mode_reg, seg_reg, laser_on_reg}, {3'h3, 5'h1f, 1'b0});
    endtask

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        wt(2);
        chk({mode_reg, seg_reg, laser_on_reg, dump_req_reg}, {3'h1, 7'h00});
        t_eff();
        t_mode();
        t_rate();
        t_long();
        t_self();
        stop_test();
    end
endmodule
